// >>> rtl/cff_pkg.sv
// Package: opcodes, field layouts, reset values, widths and states for the flush/format command block
package cff_pkg;
	// Command opcodes
	localparam logic [7:0] OP_FLUSH      = 8'he7;
	localparam logic [7:0] OP_FLUSH_EXT  = 8'hea;
	localparam logic [7:0] OP_FORMAT     = 8'hf7;
	localparam logic [7:0] OP_ERASE_PREP = 8'hf3;
	localparam logic [7:0] FEAT_FORMAT   = 8'h11;
	// Status byte bit positions
	localparam int ST_FAULT_BIT = 5;
	localparam int ST_SENSE_BIT = 1;
	localparam int ST_ERR_BIT   = 0;
	// Error byte bit position
	localparam int ER_ABORT_BIT = 2;
	// Reset values
	localparam logic [7:0]  STATUS_RST = 8'h00;
	localparam logic [7:0]  ERROR_RST  = 8'h00;
	localparam logic [47:0] ADDR_RST   = 48'h000000000000;
	localparam logic [47:0] FORMAT_START = 48'h000000000000;
	// Default widths
	localparam int ADDR_W  = 48;
	localparam int LIST_W  = 16;
	// Sequencer states
	typedef enum logic [2:0] {
		CFF_IDLE,
		CFF_FLUSH,
		CFF_MERGE,
		CFF_INIT,
		CFF_DONE
	} cff_state_t;
endpackage : cff_pkg

// >>> rtl/cff_sync.sv
// Two-flop reset release synchroniser
`timescale 1ns/10ps
module cff_sync (
	// Clock and raw reset
	input  wire logic clk_in,
	input  wire logic reset_n_in,
	// Released reset
	output logic      reset_n_out
);
	// -------------------------------------------------------------
	// State
	// -------------------------------------------------------------
	typedef struct packed {
		logic first;
		logic second;
	} cff_sync_t;

	cff_sync_t r;
	cff_sync_t next_r;

	// Shift a one in after release
	always_comb begin
		next_r        = r;
		next_r.first  = 1'b1;
		next_r.second = r.first;
	end

	// Async assert, clocked release
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign reset_n_out = r.second;
endmodule : cff_sync

// >>> rtl/cff_cmd.sv
// Flush cache / extended flush / format medium command interpreter
//
`timescale 1ns/10ps
module cff_cmd #(
	parameter int ADDR_W = cff_pkg::ADDR_W,
	parameter int LIST_W = cff_pkg::LIST_W
) (
	// Clock and reset
	input  wire logic              clk_in,
	input  wire logic              reset_n_in,
	// Command issue from the link
	input  wire logic              cmd_valid_in,
	input  wire logic [7:0]        cmd_opcode_in,
	input  wire logic [7:0]        cmd_feature_in,
	// Write cache engine
	output logic                   cache_flush_out,
	input  wire logic              cache_empty_in,
	input  wire logic              cache_fail_in,
	input  wire logic [ADDR_W-1:0] cache_fail_addr_in,
	// Medium engine
	input  wire logic [ADDR_W-1:0] native_max_in,
	output logic                   medium_write_out,
	output logic [ADDR_W-1:0]      medium_addr_out,
	input  wire logic              medium_ready_in,
	input  wire logic              medium_fail_in,
	// Defect and reassignment lists
	input  wire logic [LIST_W-1:0] reassign_count_in,
	output logic                   merge_step_out,
	output logic                   lists_clear_out,
	output logic                   lists_valid_out,
	// Device condition
	input  wire logic              device_fault_in,
	input  wire logic              sense_avail_in,
	// Completion
	output logic                   busy_out,
	output logic                   done_out,
	output logic [7:0]             status_out,
	output logic [7:0]             error_out,
	output logic [ADDR_W-1:0]      lba_out,
	output logic                   degraded_out
);
	// -------------------------------------------------------------
	// Reset release
	// -------------------------------------------------------------
	logic rst_n;

	cff_sync u_sync (
		.clk_in      (clk_in),
		.reset_n_in  (reset_n_in),
		.reset_n_out (rst_n)
	);

	// -------------------------------------------------------------
	// State
	// -------------------------------------------------------------
	typedef struct packed {
		cff_pkg::cff_state_t state;
		logic                is_format;
		logic                prep_last;
		logic                fmt_running;
		logic                degraded;
		logic                lists_valid;
		logic                flush;
		logic                mwrite;
		logic                merge;
		logic                lclear;
		logic [ADDR_W-1:0]   addr;
		logic [LIST_W-1:0]   merge_left;
		logic                done;
		logic [7:0]          status;
		logic [7:0]          error;
		logic [ADDR_W-1:0]   lba;
	} cff_cmd_t;

	cff_cmd_t r;
	cff_cmd_t next_r;

	// Decoded opcodes of an incoming command
	logic is_flush;
	logic is_fmt;
	logic take;

	// Feature, count and address fields never enter flush decode
	assign is_flush = (cmd_opcode_in == cff_pkg::OP_FLUSH) ||
	                  (cmd_opcode_in == cff_pkg::OP_FLUSH_EXT);
	assign is_fmt   = (cmd_opcode_in == cff_pkg::OP_FORMAT) &&
	                  (cmd_feature_in == cff_pkg::FEAT_FORMAT);
	assign take     = cmd_valid_in && (r.state == cff_pkg::CFF_IDLE);

	// -------------------------------------------------------------
	// Sequencer
	// -------------------------------------------------------------
	// Commands arriving while busy are dropped; the link is expected to wait
	always_comb begin
		next_r         = r;
		next_r.done    = 1'b0;
		next_r.merge   = 1'b0;
		next_r.lclear  = 1'b0;
		unique case (r.state)
			cff_pkg::CFF_IDLE: begin
				if (take) begin
					// Any command except erase-prepare breaks the pairing
					next_r.prep_last = (cmd_opcode_in == cff_pkg::OP_ERASE_PREP);
					next_r.error     = cff_pkg::ERROR_RST;
					next_r.lba       = cff_pkg::ADDR_RST;
					next_r.is_format = 1'b0;
					if (is_flush) begin
						next_r.flush = 1'b1;
						next_r.state = cff_pkg::CFF_FLUSH;
					end else if (is_fmt && r.prep_last) begin
						// Whole native range, no data phase, old lists dropped
						next_r.is_format   = 1'b1;
						next_r.fmt_running = 1'b1;
						next_r.lists_valid = 1'b0;
						next_r.merge_left  = reassign_count_in;
						next_r.addr        = cff_pkg::FORMAT_START;
						next_r.state       = cff_pkg::CFF_MERGE;
					end else if (is_fmt || (cmd_opcode_in == cff_pkg::OP_FORMAT)) begin
						// Format without prepare, or with a reserved feature value
						next_r.error[cff_pkg::ER_ABORT_BIT] = 1'b1;
						next_r.state = cff_pkg::CFF_DONE;
					end else begin
						// Other commands belong elsewhere; finish them quietly
						next_r.state = cff_pkg::CFF_DONE;
					end
				end
			end
			cff_pkg::CFF_FLUSH: begin
				if (cache_fail_in) begin
					next_r.flush = 1'b0;
					next_r.error[cff_pkg::ER_ABORT_BIT] = 1'b1;
					next_r.lba   = cache_fail_addr_in;
					next_r.state = cff_pkg::CFF_DONE;
				end else if (cache_empty_in) begin
					next_r.flush = 1'b0;
					next_r.state = cff_pkg::CFF_DONE;
				end
			end
			cff_pkg::CFF_MERGE: begin
				// Fold reassigned entries one by one, then clear the list
				if (r.merge_left != '0) begin
					next_r.merge      = 1'b1;
					next_r.merge_left = r.merge_left - 1'b1;
				end else begin
					next_r.lclear = 1'b1;
					next_r.mwrite = 1'b1;
					next_r.state  = cff_pkg::CFF_INIT;
				end
			end
			cff_pkg::CFF_INIT: begin
				if (medium_fail_in) begin
					// Unrecoverable error mid-format leaves the medium unusable
					next_r.mwrite   = 1'b0;
					next_r.degraded = 1'b1;
					next_r.error[cff_pkg::ER_ABORT_BIT] = 1'b1;
					next_r.state    = cff_pkg::CFF_DONE;
				end else if (medium_ready_in) begin
					if (r.addr == native_max_in) begin
						next_r.mwrite      = 1'b0;
						next_r.fmt_running = 1'b0;
						next_r.degraded    = 1'b0;
						next_r.lists_valid = 1'b1;
						next_r.state       = cff_pkg::CFF_DONE;
					end else begin
						next_r.addr = r.addr + 1'b1;
					end
				end
			end
			cff_pkg::CFF_DONE: begin
				next_r.done = 1'b1;
				next_r.fmt_running = 1'b0;
				next_r.status = cff_pkg::STATUS_RST;
				next_r.status[cff_pkg::ST_FAULT_BIT] = device_fault_in;
				next_r.status[cff_pkg::ST_SENSE_BIT] = sense_avail_in;
				next_r.status[cff_pkg::ST_ERR_BIT]   = r.error[cff_pkg::ER_ABORT_BIT];
				next_r.state = cff_pkg::CFF_IDLE;
			end
			default: begin
				next_r.state = cff_pkg::CFF_IDLE;
			end
		endcase
	end

	// -------------------------------------------------------------
	// Registers
	// -------------------------------------------------------------
	// A format cut short by reset is remembered: the degraded flag below is cleared
	// here, but degraded_out goes high through pend_degraded if a format was running
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			r           <= '0;
			r.state     <= cff_pkg::CFF_IDLE;
			r.status    <= cff_pkg::STATUS_RST;
			r.error     <= cff_pkg::ERROR_RST;
			r.lba       <= cff_pkg::ADDR_RST;
			r.addr      <= cff_pkg::FORMAT_START;
		end else begin
			r <= next_r;
		end
	end

	// -------------------------------------------------------------
	// Reset-interrupted format memory
	// -------------------------------------------------------------
	// Kept outside the reset domain of the sequencer: a reset pulse does not clear it
	logic fmt_pending;
	logic next_fmt_pending;
	logic pend_degraded;

	// Set while a format runs, cleared only on good format completion
	// Hold written as an if so an unknown power-up value settles to zero
	always_comb begin
		if (fmt_pending) begin
			next_fmt_pending = 1'b1;
		end else begin
			next_fmt_pending = 1'b0;
		end
		if (r.state == cff_pkg::CFF_MERGE) begin
			next_fmt_pending = 1'b1;
		end else if (r.state == cff_pkg::CFF_DONE && r.is_format && !r.degraded) begin
			next_fmt_pending = 1'b0;
		end
	end

	// Clocked without the reset: a pending format survives a reset pulse
	always_ff @(posedge clk_in) begin
		fmt_pending <= next_fmt_pending;
	end

	// Gate until the first format; survives reset so an interrupted format is seen
	logic seen_fmt;
	always_ff @(posedge clk_in) begin
		if (r.state == cff_pkg::CFF_MERGE || seen_fmt) begin
			seen_fmt <= 1'b1;
		end else begin
			seen_fmt <= 1'b0;
		end
	end
	assign pend_degraded = seen_fmt && fmt_pending && !r.fmt_running;

	// -------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------
	assign cache_flush_out  = r.flush;
	assign medium_write_out = r.mwrite;
	assign medium_addr_out  = r.addr;
	assign merge_step_out   = r.merge;
	assign lists_clear_out  = r.lclear;
	assign lists_valid_out  = r.lists_valid;
	assign busy_out         = (r.state != cff_pkg::CFF_IDLE);
	assign done_out         = r.done;
	assign status_out       = r.status;
	assign error_out        = r.error;
	assign lba_out          = r.lba;
	// Reads and writes elsewhere are refused while this is high
	assign degraded_out     = r.degraded || pend_degraded;

	// -------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------
	flush_good_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		(r.state == cff_pkg::CFF_FLUSH && !cache_fail_in && !cache_empty_in) |=> (r.state == cff_pkg::CFF_FLUSH))
		else $error("flush finished before cache empty");
	flush_start_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		(take && cmd_opcode_in == cff_pkg::OP_FLUSH) |=> (cache_flush_out && r.state == cff_pkg::CFF_FLUSH))
		else $error("flush opcode not decoded");
	flush_ext_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		(take && cmd_opcode_in == cff_pkg::OP_FLUSH_EXT) |=> cache_flush_out)
		else $error("extended flush opcode not decoded");
	flush_fail_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		(r.state == cff_pkg::CFF_FLUSH && cache_fail_in) |=> (error_out == 8'h04 && lba_out == $past(cache_fail_addr_in)))
		else $error("failed flush error fields wrong");
	status_err_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		done_out |-> (status_out[cff_pkg::ST_ERR_BIT] == error_out[cff_pkg::ER_ABORT_BIT]))
		else $error("status error bit disagrees with abort");
	no_prep_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		(take && is_fmt && !r.prep_last) |=> ##1 (done_out && error_out[cff_pkg::ER_ABORT_BIT]))
		else $error("format without prepare not aborted");
	fmt_start_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		(take && is_fmt && r.prep_last) |=> (r.state == cff_pkg::CFF_MERGE && medium_addr_out == '0 && !lists_valid_out))
		else $error("format did not start at block zero");
	merge_first_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		$rose(medium_write_out) |-> (lists_clear_out && r.merge_left == '0))
		else $error("medium written before merge finished");
	fail_degr_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		(r.state == cff_pkg::CFF_INIT && medium_fail_in) |=> degraded_out [*2])
		else $error("interrupted format not degraded");
	degr_exit_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		($fell(r.degraded)) |-> (r.state == cff_pkg::CFF_DONE && r.is_format && lists_valid_out))
		else $error("degraded mode left without good format");
endmodule : cff_cmd

// >>> verif/cff_engine_model.sv
// Behavioural cache and medium engines on the far side of the command block
`timescale 1ns/10ps
module cff_engine_model (
	// Controls from the bench
	input  wire logic        clk_in,
	input  wire logic [2:0]  delay_in,
	input  wire logic        cache_bad_in,
	input  wire logic        medium_bad_in,
	input  wire logic [47:0] bad_addr_in,
	// Cache engine
	input  wire logic        cache_flush_in,
	output logic             cache_empty_out,
	output logic             cache_fail_out,
	output logic [47:0]      cache_fail_addr_out,
	// Medium engine
	input  wire logic        medium_write_in,
	input  wire logic [47:0] medium_addr_in,
	output logic             medium_ready_out,
	output logic             medium_fail_out
);
	logic [3:0] cache_wait = 4'h0;
	logic [3:0] medium_wait = 4'h0;
	initial begin
		{cache_empty_out, cache_fail_out, medium_ready_out, medium_fail_out} = 4'h0;
		cache_fail_addr_out = 48'h0;
	end
	// Commit takes a variable time; the address is only meaningful while failing
	always @(posedge clk_in) begin
		cache_fail_addr_out <= (cache_flush_in === 1'b1 && cache_wait >= {1'b0, delay_in} && cache_bad_in) ?
		                       bad_addr_in : ~cache_fail_addr_out;
		if (cache_flush_in !== 1'b1) begin
			cache_wait <= 4'h0;
			{cache_empty_out, cache_fail_out} <= 2'b00;
		end else if (cache_wait < {1'b0, delay_in}) begin
			cache_wait <= cache_wait + 4'h1;
		end else begin
			{cache_empty_out, cache_fail_out} <= {!cache_bad_in, cache_bad_in};
		end
	end
	// One ready pulse per block, no data phase with the host
	always @(posedge clk_in) begin
		{medium_ready_out, medium_fail_out} <= 2'b00;
		if (medium_write_in !== 1'b1 || medium_ready_out || medium_fail_out) begin
			medium_wait <= 4'h0;
		end else if (medium_wait < {1'b0, delay_in}) begin
			medium_wait <= medium_wait + 4'h1;
		end else if (medium_bad_in && medium_addr_in == bad_addr_in) begin
			medium_fail_out <= 1'b1;
		end else begin
			medium_ready_out <= 1'b1;
		end
	end
endmodule : cff_engine_model

// >>> verif/cache_flush_format_cmds_bench.sv
// Self-checking bench for the flush and format command block
`timescale 1ns/10ps
module cache_flush_format_cmds_bench;
	logic clk_in, reset_n_in, cmd_valid_in, cache_flush_out, cache_empty_in, cache_fail_in;
	logic medium_write_out, medium_ready_in, medium_fail_in, merge_step_out, lists_clear_out;
	logic lists_valid_out, device_fault_in, sense_avail_in, busy_out, done_out, degraded_out;
	logic cache_bad, medium_bad, seen;
	logic [2:0] delay;
	logic [7:0] cmd_opcode_in, cmd_feature_in, status_out, error_out;
	logic [15:0] reassign_count_in;
	logic [47:0] cache_fail_addr_in, native_max_in, medium_addr_out, lba_out, bad_addr, exp_addr, fa;
	logic [16:0] lfsr;
	logic [63:0] expq[$];
	int fails, total_checks, cycles, merges;
	cff_cmd u_cff_cmd (.clk_in(clk_in), .reset_n_in(reset_n_in), .cmd_valid_in(cmd_valid_in),
		.cmd_opcode_in(cmd_opcode_in), .cmd_feature_in(cmd_feature_in), .cache_flush_out(cache_flush_out),
		.cache_empty_in(cache_empty_in), .cache_fail_in(cache_fail_in), .cache_fail_addr_in(cache_fail_addr_in),
		.native_max_in(native_max_in), .medium_write_out(medium_write_out), .medium_addr_out(medium_addr_out),
		.medium_ready_in(medium_ready_in), .medium_fail_in(medium_fail_in),
		.reassign_count_in(reassign_count_in), .merge_step_out(merge_step_out),
		.lists_clear_out(lists_clear_out), .lists_valid_out(lists_valid_out),
		.device_fault_in(device_fault_in), .sense_avail_in(sense_avail_in), .busy_out(busy_out),
		.done_out(done_out), .status_out(status_out), .error_out(error_out), .lba_out(lba_out),
		.degraded_out(degraded_out));
	cff_engine_model u_cff_engine_model (.clk_in(clk_in), .delay_in(delay), .cache_bad_in(cache_bad),
		.medium_bad_in(medium_bad), .bad_addr_in(bad_addr), .cache_flush_in(cache_flush_out),
		.cache_empty_out(cache_empty_in), .cache_fail_out(cache_fail_in),
		.cache_fail_addr_out(cache_fail_addr_in), .medium_write_in(medium_write_out),
		.medium_addr_in(medium_addr_out), .medium_ready_out(medium_ready_in), .medium_fail_out(medium_fail_in));
	// ------------------------------------------------
	// Helpers
	// ------------------------------------------------
	function automatic logic [16:0] step(input logic [16:0] v);
		return {v[15:0], v[16] ^ v[13]};
	endfunction : step
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic conclude;
		$display("Checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude
	// Issue one command and note its expected completion
	task automatic run(input logic [7:0] op, input logic [7:0] feat, input logic err, input logic [47:0] lba);
		int n;
		lfsr = step(lfsr);
		seen = 1'b0;
		{device_fault_in, sense_avail_in, delay} <= lfsr[4:0];
		{cmd_opcode_in, cmd_feature_in, cmd_valid_in} <= {op, feat, 1'b1};
		expq.push_back({2'b00, lfsr[4], 3'b000, lfsr[3], err, 5'h0, err, 2'b00, lba});
		@(posedge clk_in);
		cmd_valid_in <= 1'b0;
		@(posedge clk_in);
		check(busy_out, 1);
		n = 1;
		while (done_out !== 1'b1 && n < 300) begin
			@(posedge clk_in);
			n++;
		end
		if (done_out !== 1'b1) begin
			fails++;
			conclude();
		end
		if (op == cff_pkg::OP_FLUSH || op == cff_pkg::OP_FLUSH_EXT) check(seen, 1);
	endtask : run
	task automatic format(input logic err, input logic [2:0] nmax);
		merges = 0;
		exp_addr = 48'h0;
		lfsr = step(lfsr);
		reassign_count_in <= {13'h0, lfsr[7:5]};
		native_max_in <= {45'h0, nmax};
		run(cff_pkg::OP_ERASE_PREP, 8'h00, 1'b0, 48'h0);
		run(cff_pkg::OP_FORMAT, cff_pkg::FEAT_FORMAT, err, 48'h0);
	endtask : format
	// ------------------------------------------------
	// Clock, watchdog and result watcher
	// ------------------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	// Completion pops the oldest note; merge and medium traffic checked as it passes
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			conclude();
		end
		if (cache_empty_in === 1'b1 || cache_fail_in === 1'b1) seen = 1'b1;
		if (merge_step_out === 1'b1) merges++;
		if (lists_clear_out === 1'b1) check(64'(merges), 64'(reassign_count_in));
		if (medium_write_out === 1'b1 && medium_ready_in === 1'b1) begin
			check({15'h0, lists_valid_out, medium_addr_out}, {16'h0, exp_addr});
			exp_addr = exp_addr + 48'h1;
		end
		if (done_out === 1'b1) check({status_out, error_out, lba_out}, expq.pop_front());
	end
	// ------------------------------------------------
	// Scenarios
	// ------------------------------------------------
	initial begin
		{reset_n_in, cmd_valid_in, cmd_opcode_in, cmd_feature_in, device_fault_in, sense_avail_in} = 0;
		{cache_bad, medium_bad, delay, bad_addr, reassign_count_in, native_max_in} = 0;
		lfsr = 17'd97439;
		repeat (8) @(posedge clk_in);
		reset_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		for (int i = 0; i < 6; i++) run(i[0] ? cff_pkg::OP_FLUSH_EXT : cff_pkg::OP_FLUSH, lfsr[12:5], 0, 0);
		fa = {31'h0, lfsr};
		{bad_addr, cache_bad} <= {fa, 1'b1};
		run(cff_pkg::OP_FLUSH_EXT, 8'h00, 1'b1, fa);
		cache_bad <= 1'b0;
		run(cff_pkg::OP_FORMAT, cff_pkg::FEAT_FORMAT, 1'b1, 48'h0);
		run(cff_pkg::OP_ERASE_PREP, 8'h00, 1'b0, 48'h0);
		run(cff_pkg::OP_FORMAT, 8'h12, 1'b1, 48'h0);
		run(cff_pkg::OP_ERASE_PREP, 8'h00, 1'b0, 48'h0);
		run(cff_pkg::OP_FLUSH, 8'h00, 1'b0, 48'h0);
		run(cff_pkg::OP_FORMAT, cff_pkg::FEAT_FORMAT, 1'b1, 48'h0);
		format(1'b0, 3'h5);
		check({lists_valid_out, degraded_out, exp_addr}, {2'b10, 48'h6});
		{bad_addr, medium_bad} <= {48'h3, 1'b1};
		format(1'b1, 3'h7);
		medium_bad <= 1'b0;
		run(cff_pkg::OP_FLUSH, 8'h00, 1'b0, 48'h0);
		check(degraded_out, 1);
		format(1'b0, 3'h0);
		check({lists_valid_out, degraded_out, exp_addr}, {2'b10, 48'h1});
		// Reset in the middle of a format leaves the medium unusable
		native_max_in <= 48'h3f;
		exp_addr = 48'h0;
		merges = 0;
		run(cff_pkg::OP_ERASE_PREP, 8'h00, 1'b0, 48'h0);
		{cmd_opcode_in, cmd_feature_in, cmd_valid_in} <= {cff_pkg::OP_FORMAT, cff_pkg::FEAT_FORMAT, 1'b1};
		@(posedge clk_in);
		cmd_valid_in <= 1'b0;
		repeat (6) @(posedge clk_in);
		reset_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		reset_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		check(degraded_out, 1);
		format(1'b0, 3'h2);
		check(degraded_out, 0);
		conclude();
	end
endmodule : cache_flush_format_cmds_bench
